// file: ssps_sram.sv
`timescale 1ns/100ps
// Behaviour
// RULE_01 - Address, data and all controls registered on each clock edge.
// RULE_02 - Array is 131072 words of 9 bits, 17-bit address.
// RULE_03 - Select and write taken at edge n, output enable at n+1.
// RULE_04 - Select, write, oe low: write and echo data; oe high: write, float.
// RULE_05 - Deselected write with oe low passes data through, no write.
// RULE_06 - Deselected write with oe high is an idle cycle, outputs float.
// RULE_07 - Write enable high reads; stored word driven when oe low.
// RULE_08 - Output shows stored word or last valid read result.
// RULE_09 - Controller keeps inputs stable around edges while selected.
// RULE_10 - Scan uses serial in, serial out, test clock and mode select.
// RULE_11 - Modes are normal, scan and bypass.
// RULE_12 - Controller holds test clock and mode select low for normal use.
// RULE_13 - Normal mode resumes on first clock edge with both low.
// RULE_14 - Raising mode select parallel-loads chain from input registers.
// RULE_15 - In scan, capture on test clock rise, shift out on fall.
// RULE_16 - Bypass: sample input on rise, drive it on next fall.
// RULE_17 - Scan only watches RAM inputs and never disturbs operation.
// RULE_18 - Controller waits 10 ns from normal to scan.
// RULE_19 - Controller waits 10 ns from shift to bypass.
// RULE_20 - Controller allows 100 ns recovery before normal operation.
// RULE_21 - Test clock low 10 ns before load, 10 ns before shift.
// RULE_22 - Test clock period 100 ns, phases 40 ns at least.
// RULE_23 - Chain only samples inputs; never drives RAM pins.
// RULE_24 - Chain order address, control, data; first out is first element.
// RULE_25 - Writes complete in one cycle; back-to-back writes accepted.
module ssps_sram
   import ssps_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [AW-1:0] word_address_i,
   input wire logic [DW-1:0] write_data_in_i,
   input wire logic chip_sel_n_i,
   input wire logic write_en_n_i,
   input wire logic out_en_n_i,
   output logic [DW-1:0] read_data_out_o,
   output logic read_data_oe_o,
   input wire logic test_clk_i,
   input wire logic scan_sel_i,
   input wire logic scan_di_i,
   output logic scan_do_o,
   output ssps_pkg::ssps_mode_t scan_mode_o
);
   import ssps_pkg::*;

   // ==========================================================
   // Input registers
   ssps_in_t in_r;
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] q_r;
   logic q_oe_r;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         in_r <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
      end else begin
         in_r.addr <= word_address_i; // see RULE_01
         in_r.wdata <= write_data_in_i;
         in_r.cs_n <= chip_sel_n_i;
         in_r.we_n <= write_en_n_i;
         in_r.oe_n <= out_en_n_i;
      end
   end

   // ==========================================================
   // Array and output; oe of the current edge governs the
   // result of the operation registered one edge earlier
   logic wr_hit;
   assign wr_hit = !in_r.cs_n && !in_r.we_n;

   // No reset on storage: a RAM array has no defined contents
   always_ff @(posedge clk_i) begin
      if (wr_hit) begin
         mem[in_r.addr] <= in_r.wdata; // see RULE_04 see RULE_25 see RULE_02
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q_r <= '0;
         q_oe_r <= 1'b0;
      end else begin
         q_oe_r <= !out_en_n_i; // see RULE_03
         if (!in_r.we_n) begin
            q_r <= in_r.wdata; // see RULE_04 see RULE_05 see RULE_06
         end else begin
            q_r <= mem[in_r.addr]; // see RULE_07 see RULE_08
         end
      end
   end

   assign read_data_out_o = q_r;
   assign read_data_oe_o = q_oe_r;

   // ==========================================================
   // Test pin synchronisers; a level counts only once stages
   // two and three agree, so a slow ragged edge is seen once
   logic [SYNC_STAGES-1:0] tck_s, tms_s, tdi_s;
   logic tck_lvl_r, tms_lvl_r, tdi_lvl_r;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tck_s <= '0;
         tms_s <= '0;
         tdi_s <= '0;
      end else begin
         tck_s <= {tck_s[1:0], test_clk_i}; // see RULE_10
         tms_s <= {tms_s[1:0], scan_sel_i};
         tdi_s <= {tdi_s[1:0], scan_di_i};
      end
   end

   // Filtered levels; reset to the idle level of the pins so
   // that no false edge follows reset
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tck_lvl_r <= 1'b0;
         tms_lvl_r <= 1'b0;
         tdi_lvl_r <= 1'b0;
      end else begin
         if (tck_s[1] == tck_s[2]) begin
            tck_lvl_r <= tck_s[2];
         end
         if (tms_s[1] == tms_s[2]) begin
            tms_lvl_r <= tms_s[2];
         end
         if (tdi_s[1] == tdi_s[2]) begin
            tdi_lvl_r <= tdi_s[2];
         end
      end
   end

   logic tck_rise, tck_fall, tms_rise, tck_q, tms_q;
   assign tck_rise = tck_s[1] && tck_s[2] && !tck_lvl_r;
   assign tck_fall = !tck_s[1] && !tck_s[2] && tck_lvl_r;
   assign tms_rise = tms_s[1] && tms_s[2] && !tms_lvl_r;
   assign tck_q = tck_lvl_r;
   assign tms_q = tms_lvl_r;

   // ==========================================================
   // Scan mode and shadow chain
   ssps_mode_t mode_r;
   logic [CHAIN_W-1:0] shadow_scan_register_r;
   logic cap_r, byp_r, do_r;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_r <= SSPS_NORMAL;
      end else begin
         case (mode_r)
            SSPS_NORMAL: begin
               if (tms_rise) begin
                  mode_r <= SSPS_SCAN; // see RULE_11
               end else if (tck_rise) begin
                  mode_r <= SSPS_BYPASS; // see RULE_16
               end
            end
            SSPS_SCAN, SSPS_BYPASS: begin
               if (!tck_q && !tms_q) begin
                  mode_r <= SSPS_NORMAL; // see RULE_13
               end else if (tms_rise) begin
                  mode_r <= SSPS_SCAN;
               end else if (tck_rise && !tms_q) begin
                  mode_r <= SSPS_BYPASS;
               end
            end
            default: mode_r <= SSPS_NORMAL;
         endcase
      end
   end

   // Chain only reads in_r, so RAM operation is untouched
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         shadow_scan_register_r <= '0;
         cap_r <= 1'b0;
      end else if (tms_rise) begin
         shadow_scan_register_r <= in_r; // see RULE_14 see RULE_17 see RULE_24
      end else if (tms_q && tck_rise) begin
         cap_r <= tdi_lvl_r; // see RULE_15
      end else if (tms_q && tck_fall) begin
         shadow_scan_register_r <= {shadow_scan_register_r[CHAIN_W-2:0],
                                    cap_r};
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         byp_r <= 1'b0;
      end else if (!tms_q && tck_rise) begin
         byp_r <= tdi_lvl_r; // see RULE_16
      end
   end

   // Output holds first chain element straight after load
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         do_r <= 1'b0;
      end else if (tms_rise) begin
         do_r <= in_r.addr[AW-1]; // see RULE_24
      end else if (tck_fall) begin
         do_r <= tms_q ? shadow_scan_register_r[CHAIN_ADDR_POS - 1] : byp_r;
      end
   end

   assign scan_do_o = do_r; // see RULE_23
   assign scan_mode_o = mode_r;

   // ==========================================================
   // Checks
   sequence s_write;
      !in_r.cs_n && !in_r.we_n;
   endsequence

   AST_WR_ECHO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !in_r.we_n |=> q_r == $past(in_r.wdata)) // see RULE_04
      else $error("write data not echoed");
   // Case equality: words never written read back unknown
   AST_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      in_r.we_n |=> q_r === $past(mem[in_r.addr])) // see RULE_07
      else $error("read data wrong");
   AST_WR_STORE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write |=> mem[$past(in_r.addr)] == $past(in_r.wdata)) // see RULE_25
      else $error("write not stored");
   AST_OE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 read_data_oe_o == !$past(out_en_n_i)) // see RULE_03
      else $error("output enable timing wrong");
   AST_CAPTURE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      tms_rise |=> shadow_scan_register_r == $past(in_r)) // see RULE_14
      else $error("parallel load missed");
   AST_NORMAL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!tck_q && !tms_q && !tms_rise && !tck_rise) |=>
      mode_r == SSPS_NORMAL) // see RULE_13
      else $error("normal mode not resumed");
   AST_BYPASS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!tms_q && tck_fall) |=> do_r == $past(byp_r)) // see RULE_16
      else $error("bypass data wrong");
   AST_SCAN_SHIFT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tms_q && tck_fall && !tms_rise) |=>
      shadow_scan_register_r[0] == $past(cap_r)) // see RULE_15
      else $error("scan shift wrong");
endmodule

// file: ssps_pkg.sv
package ssps_pkg;
   // ==========================================================
   // Array geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 9;
   localparam int DEPTH = 131072;
   // Scan chain: address, then controls (cs, we, oe), then data
   localparam int CTRL_W = 3;
   localparam int CHAIN_W = ADDR_W + CTRL_W + DATA_W;
   localparam int CHAIN_ADDR_POS = CHAIN_W - 1;
   localparam int SYNC_STAGES = 3;
   // ==========================================================
   // Input register contents
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic [DATA_W-1:0] wdata;
   } ssps_in_t;
   typedef enum logic [1:0] {SSPS_NORMAL, SSPS_SCAN, SSPS_BYPASS}
      ssps_mode_t;
endpackage

// file: ssps_ctrl_model.sv
`timescale 1ns/100ps
module ssps_ctrl_model
   import ssps_pkg::*;
(
   input wire logic clk_i,
   input wire logic [DATA_W-1:0] read_data_out_i,
   input wire logic read_data_oe_i,
   output logic [ADDR_W-1:0] word_address_o,
   output logic [DATA_W-1:0] write_data_in_o,
   output logic chip_sel_n_o,
   output logic write_en_n_o,
   output logic out_en_n_o
);
   import ssps_pkg::*;
   ssps_in_t req;
   initial req = '{'0, 1'b1, 1'b1, 1'b1, '0};
   assign word_address_o = req.addr;
   assign write_data_in_o = req.wdata;
   assign chip_sel_n_o = req.cs_n;
   assign write_en_n_o = req.we_n;
   assign out_en_n_o = req.oe_n;
   // Pins move only at falling edges, well clear of capture
   task automatic op(input logic cs, we, oe,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] q, output logic q_oe);
      @(negedge clk_i);
      req = '{a, cs, we, oe, d};
      @(negedge clk_i);
      // Output enable belongs to the following edge
      req.cs_n = 1'b1;
      req.we_n = 1'b1;
      req.wdata = ~d;
      @(negedge clk_i);
      q = read_data_out_i;
      q_oe = read_data_oe_i;
      req.oe_n = 1'b1;
   endtask
   task automatic wr2(input logic [ADDR_W-1:0] a1, a2,
      input logic [DATA_W-1:0] d1, d2);
      @(negedge clk_i);
      req = '{a1, 1'b0, 1'b0, 1'b1, d1};
      @(negedge clk_i);
      req = '{a2, 1'b0, 1'b0, 1'b1, d2};
      @(negedge clk_i);
      req = '{a2, 1'b1, 1'b1, 1'b1, ~d2};
   endtask
endmodule

// file: tb_sync_sram_passthru_scan.sv
`timescale 1ns/100ps
module tb_sync_sram_passthru_scan;
   import ssps_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, tck = 0, tsel = 0, tdi = 0;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] wd, q, rq;
   logic cs_n, we_n, oe_n, qoe, roe, sdo;
   logic [CHAIN_W-1:0] chain;
   ssps_mode_t mode;
   int n_mismatch = 0, n_tests = 0;
   initial forever #4 clk_i = ~clk_i;
   ssps_ctrl_model u_ctrl(.clk_i(clk_i), .read_data_out_i(q),
      .read_data_oe_i(qoe), .word_address_o(a), .write_data_in_o(wd),
      .chip_sel_n_o(cs_n), .write_en_n_o(we_n), .out_en_n_o(oe_n));
   ssps_sram u_dut(.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .word_address_i(a), .write_data_in_i(wd), .chip_sel_n_i(cs_n),
      .write_en_n_i(we_n), .out_en_n_i(oe_n), .read_data_out_o(q),
      .read_data_oe_o(qoe), .test_clk_i(tck), .scan_sel_i(tsel),
      .scan_di_i(tdi), .scan_do_o(sdo), .scan_mode_o(mode));
   // ==========================================================
   // Checking
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] ad, input logic [8:0] e);
      u_ctrl.op(1'b1, 1'b1, 1'b0, ad, 9'h000, rq, roe);
      check(rq, e);
      check(roe, 1);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_ram();
      u_ctrl.op(0, 0, 0, 17'h1FFFF, 9'h1A5, rq, roe);
      check(rq, 9'h1A5);
      check(roe, 1);
      u_ctrl.op(0, 0, 1, 17'h00002, 9'h05A, rq, roe);
      check(roe, 0);
      rd(17'h1FFFF, 9'h1A5);
      u_ctrl.op(0, 1, 1, 17'h00002, 9'h000, rq, roe);
      check(roe, 0);
      rd(17'h00002, 9'h05A);
   endtask
   task automatic t_pass();
      u_ctrl.op(1, 0, 0, 17'h1FFFF, 9'h0C3, rq, roe);
      check(rq, 9'h0C3);
      check(roe, 1);
      u_ctrl.op(1, 0, 1, 17'h1FFFF, 9'h13C, rq, roe);
      check(roe, 0);
      rd(17'h1FFFF, 9'h1A5);
   endtask
   task automatic t_b2b();
      u_ctrl.wr2(17'h00010, 17'h00011, 9'h1FF, 9'h100);
      rd(17'h00010, 9'h1FF);
      rd(17'h00011, 9'h100);
   endtask
   task automatic t_scan();
      chain = u_ctrl.req;
      repeat (2) @(negedge clk_i);
      tsel = 1;
      repeat (10) @(negedge clk_i);
      check(mode, SSPS_SCAN);
      check(sdo, chain[CHAIN_W-1]);
      for (int i = 1; i <= CHAIN_W; i++) begin
         tdi = i[0];
         // Serial input settles well before the test clock rises
         repeat (2) @(negedge clk_i);
         tck = 1;
         repeat (6) @(negedge clk_i);
         tck = 0;
         repeat (5) @(negedge clk_i);
         check(sdo, i < CHAIN_W ? chain[CHAIN_W-1-i] : 1'b1);
      end
      tsel = 0;
      repeat (13) @(negedge clk_i);
      check(mode, SSPS_NORMAL);
      rd(17'h1FFFF, 9'h1A5);
   endtask
   task automatic t_bypass();
      for (int v = 0; v < 2; v++) begin
         tdi = v[0];
         repeat (2) @(negedge clk_i);
         tck = 1;
         repeat (6) @(negedge clk_i);
         check(mode, SSPS_BYPASS);
         tck = 0;
         repeat (5) @(negedge clk_i);
         check(sdo, v[0]);
         check(mode, SSPS_NORMAL);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 0;
      t_ram();
      t_pass();
      t_b2b();
      t_scan();
      t_bypass();
      conclude();
   end
   // Whole run needs about 470 cycles
   initial begin
      repeat (3000) @(posedge clk_i);
      n_mismatch++;
      conclude();
   end
endmodule
